// [verilog/pms_pkg.sv]
package pms_pkg;

  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    pms_coin, pms_off, pms_cold, pms_wdog, pms_on,
    pms_uow, pms_memh, pms_uoff, pms_warm, pms_power_cut
  } pms_state_e;

  // ----------------------------------------------------------------
  // Register port geometry and offsets
  // ----------------------------------------------------------------
  localparam int PMS_AW = 3;
  localparam int PMS_DW = 8;
  localparam int PMS_NBUCK = 5;
  localparam int PMS_NPUPS = 4;
  localparam logic [PMS_AW-1:0] PMS_ADDR_CTRL = 3'h0;
  localparam logic [PMS_AW-1:0] PMS_ADDR_USEROFF = 3'h1;
  localparam logic [PMS_AW-1:0] PMS_ADDR_MHMODE = 3'h2;
  localparam logic [PMS_AW-1:0] PMS_ADDR_UOMODE = 3'h3;
  localparam logic [PMS_AW-1:0] PMS_ADDR_FLAGS = 3'h4;
  localparam logic [PMS_AW-1:0] PMS_ADDR_STATE = 3'h5;

  // Control register fields (coin-cell domain)
  localparam int PMS_CTRL_WARM_START_ENABLE = 0;
  localparam int PMS_CTRL_SILENT = 1;
  localparam int PMS_CTRL_MCUCLK = 2;
  localparam int PMS_CTRL_UOCLK = 3;
  localparam int PMS_CTRL_OVRD = 4;
  localparam int PMS_CTRL_PCUTEN = 5;
  localparam int PMS_CTRL_W = 6;
  localparam int PMS_USEROFF_BIT = 0;

  // Sticky flag fields
  localparam int PMS_FLAG_MEMH = 0;
  localparam int PMS_FLAG_WARM = 1;
  localparam int PMS_NFLAG = 2;

  // Reset values
  localparam logic [PMS_CTRL_W-1:0] PMS_CTRL_RST = 6'h00;
  localparam logic [PMS_NBUCK-1:0] PMS_MODE_RST = 5'h00;

  // ----------------------------------------------------------------
  // Timing, counted in 32 kHz oscillator ticks
  // ----------------------------------------------------------------
  localparam int PMS_TW = 16;
  localparam int PMS_OSC_HZ = 32768;
  localparam int PMS_INIT_TIME_US = 8000;
  localparam logic [PMS_TW-1:0] PMS_INIT_TICKS =
    PMS_TW'((PMS_INIT_TIME_US * PMS_OSC_HZ + 999999) / 1000000);
  localparam logic [PMS_TW-1:0] PMS_RESET_TICKS = 16'h0200;
  localparam logic [PMS_TW-1:0] PMS_WDOG_TICKS = 16'h0400;
  localparam logic [PMS_TW-1:0] PMS_WAIT_TICKS = 16'h0800;
  localparam logic [PMS_TW-1:0] PMS_POWER_CUT_TICKS = 16'h1000;

endpackage

// [verilog/pms_timer.sv]
`timescale 1ns/100ps
module pms_timer
  import pms_pkg::*;
#(
  parameter int W = PMS_TW
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] len,
  input wire logic tick,
  output logic running,
  output logic done
);

  // ----------------------------------------------------------------
  // Down counter on oscillator ticks
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } pms_tmr_s;

  pms_tmr_s q;
  pms_tmr_s n;

  // A reload cancels a pending expiry so a stale end never leaks
  always_comb begin
    n = q;
    n.done = 1'b0;
    if (load) begin
      n.cnt = len;
    end else if (tick && q.cnt != '0) begin
      n.cnt = q.cnt - 1'b1;
      n.done = (q.cnt == W'(1));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign running = (q.cnt != '0);
  assign done = q.done;

endmodule

// [verilog/pms_fsm.sv]
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module pms_fsm
  import pms_pkg::*;
#(
  parameter logic [PMS_TW-1:0] RESET_TICKS = PMS_RESET_TICKS,
  parameter logic [PMS_TW-1:0] WDOG_TICKS = PMS_WDOG_TICKS,
  parameter logic [PMS_TW-1:0] WAIT_TICKS = PMS_WAIT_TICKS,
  parameter logic [PMS_TW-1:0] POWER_CUT_TICKS = PMS_POWER_CUT_TICKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic osc_tick,
  input wire logic slow_clock_in,
  input wire logic always_on_supply_ok,
  input wire logic backup_cell_ok,
  input wire logic turn_on_event,
  input wire logic keepalive_input,
  input wire logic irq_request,
  input wire logic [PMS_NPUPS-1:0] power_up_select_pins,
  input wire logic [PMS_AW-1:0] reg_addr,
  input wire logic [PMS_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [PMS_DW-1:0] reg_rdata,
  output logic system_reset_n_out,
  output logic system_reset_n_oe,
  output logic processor_reset_n_out,
  output logic processor_reset_n_oe,
  output logic irq_out,
  output logic peripheral_slow_clock,
  output logic processor_slow_clock,
  output logic [PMS_NBUCK-1:0] buck_enable,
  output logic [PMS_NBUCK-1:0] buck_low_power,
  output logic ldo_enable,
  output logic regulator_seq_go,
  output logic [PMS_NPUPS-1:0] pups_latched
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    pms_state_e st;
    logic sys_rst_n;
    logic mcu_rst_n;
    logic irq;
    logic pclk_en;
    logic mclk_en;
    logic ldo_en;
    logic seq;
    logic [PMS_NBUCK-1:0] buck_en;
    logic [PMS_NBUCK-1:0] buck_lp;
    logic [PMS_NBUCK-1:0] keep;
    logic [PMS_CTRL_W-1:0] ctrl;
    logic [PMS_NBUCK-1:0] mhm;
    logic [PMS_NBUCK-1:0] uom;
    logic uoreq;
    logic [PMS_NFLAG-1:0] flags;
    logic [PMS_NPUPS-1:0] pups;
    logic [PMS_DW-1:0] rdata;
  } pms_regs_s;

  pms_regs_s q;
  pms_regs_s n;
  pms_state_e nx;
  logic enter;
  logic st_done;
  logic init_done;
  logic aon_ok;

  // Powered states where the processor is alive
  function automatic logic fn_awake(input pms_state_e s);
    return (s == pms_wdog) || (s == pms_on) || (s == pms_uow);
  endfunction

  // States that collapse on a supply drop
  function automatic logic fn_powered(input pms_state_e s);
    return fn_awake(s) || (s == pms_cold) || (s == pms_warm);
  endfunction

  // Timer length for each state; zero means no timer runs
  function automatic logic [PMS_TW-1:0] fn_len(input pms_state_e s);
    unique case (s)
      pms_cold, pms_warm: return RESET_TICKS;
      pms_wdog: return WDOG_TICKS;
      pms_uow: return WAIT_TICKS;
      pms_power_cut: return POWER_CUT_TICKS;
      default: return '0;
    endcase
  endfunction

  assign aon_ok = always_on_supply_ok;

  // ----------------------------------------------------------------
  // Timers on the 32 kHz tick
  // ----------------------------------------------------------------
  // Reloaded on every state change so each state starts fresh
  pms_timer #(.W(PMS_TW)) u_state_tmr (
    .clk(clk),
    .rst_n(rst_n),
    .load(enter),
    .len(fn_len(nx)),
    .tick(osc_tick),
    .running(),
    .done(st_done)
  );

  // Initialisation window before sequencing starts
  pms_timer #(.W(PMS_TW)) u_init_tmr (
    .clk(clk),
    .rst_n(rst_n),
    .load(enter && (nx == pms_cold || nx == pms_warm)),
    .len(PMS_INIT_TICKS),
    .tick(osc_tick),
    .running(),
    .done(init_done)
  );

  // ----------------------------------------------------------------
  // Next state, register port and outputs
  // ----------------------------------------------------------------
  always_comb begin
    n = q;
    nx = q.st;
    n.rdata = '0;
    // Writes and reads only while the processor owns the port
    if (reg_wr && fn_awake(q.st)) begin
      unique case (reg_addr)
        PMS_ADDR_CTRL: n.ctrl = reg_wdata[PMS_CTRL_W-1:0];
        PMS_ADDR_USEROFF: n.uoreq = reg_wdata[PMS_USEROFF_BIT];
        PMS_ADDR_MHMODE: n.mhm = reg_wdata[PMS_NBUCK-1:0];
        PMS_ADDR_UOMODE: n.uom = reg_wdata[PMS_NBUCK-1:0];
        PMS_ADDR_FLAGS: n.flags = q.flags & ~reg_wdata[PMS_NFLAG-1:0];
        default: n.ctrl = q.ctrl;
      endcase
    end
    if (reg_rd && fn_awake(q.st)) begin
      unique case (reg_addr)
        PMS_ADDR_CTRL: n.rdata = PMS_DW'(q.ctrl);
        PMS_ADDR_USEROFF: n.rdata = PMS_DW'(q.uoreq);
        PMS_ADDR_MHMODE: n.rdata = PMS_DW'(q.mhm);
        PMS_ADDR_UOMODE: n.rdata = PMS_DW'(q.uom);
        PMS_ADDR_FLAGS: n.rdata = PMS_DW'(q.flags);
        PMS_ADDR_STATE: n.rdata = PMS_DW'(q.st);
        default: n.rdata = '0;
      endcase
    end
    // Supply loss first: nothing else matters once it is gone
    if (fn_powered(q.st) && !aon_ok) begin
      nx = q.ctrl[PMS_CTRL_PCUTEN] ? pms_power_cut : pms_off;
    end else begin
      unique case (q.st)
        pms_coin: begin
          if (!backup_cell_ok) begin
            n.ctrl = PMS_CTRL_RST;
            n.mhm = PMS_MODE_RST;
            n.uom = PMS_MODE_RST;
            n.uoreq = 1'b0;
            n.flags = '0;
          end else if (aon_ok) begin
            nx = pms_off;
          end
        end
        pms_off: begin
          // Turn-on only counts with a good supply
          if (turn_on_event && aon_ok) begin
            nx = pms_cold;
          end
        end
        pms_cold: begin
          // Keepalive deliberately not looked at here
          if (st_done) begin
            nx = pms_wdog;
          end
        end
        pms_wdog: begin
          if (st_done) begin
            nx = pms_on;
          end
        end
        pms_on: begin
          // Request wins so a processor dropping keepalive after
          // asking for user off is not mistaken for a crash
          if (q.uoreq) begin
            nx = pms_uow;
          end else if (!keepalive_input) begin
            nx = q.ctrl[PMS_CTRL_SILENT] ? pms_cold : pms_off;
          end
        end
        pms_uow: begin
          if (st_done) begin
            nx = q.ctrl[PMS_CTRL_WARM_START_ENABLE] ? pms_uoff : pms_memh;
            n.uoreq = 1'b0;
          end
        end
        pms_memh: begin
          if (turn_on_event) begin
            nx = pms_cold;
            n.keep = q.mhm;
            n.mhm = PMS_MODE_RST;
            n.uom = PMS_MODE_RST;
          end
        end
        pms_uoff: begin
          if (turn_on_event) begin
            nx = pms_warm;
            n.keep = q.uom;
            n.mhm = PMS_MODE_RST;
            n.uom = PMS_MODE_RST;
          end
        end
        pms_warm: begin
          if (st_done) begin
            nx = pms_wdog;
          end
        end
        pms_power_cut: begin
          if (aon_ok) begin
            nx = pms_cold;
          end else if (st_done) begin
            nx = pms_off;
          end
        end
        default: nx = pms_coin;
      endcase
    end
    // Wake flags: the set is applied after the clear, so it wins
    if (q.st == pms_memh && nx == pms_cold) begin
      n.flags[PMS_FLAG_MEMH] = 1'b1;
    end
    if (q.st == pms_warm && nx == pms_wdog) begin
      n.flags[PMS_FLAG_WARM] = 1'b1;
    end
    n.st = nx;
    // Latch pins and hold off sequencing through initialisation
    // Compared locally so the process does not read its own result
    if (nx != q.st && (nx == pms_cold || nx == pms_warm)) begin
      n.pups = power_up_select_pins;
      n.seq = 1'b0;
    end else if (init_done && (q.st == pms_cold || q.st == pms_warm)) begin
      n.seq = 1'b1;
    end
    if (nx == pms_wdog) begin
      n.keep = '0;
    end
    // Reset pins follow the state being entered
    n.sys_rst_n = fn_awake(nx);
    n.mcu_rst_n = fn_awake(nx) || nx == pms_uoff || nx == pms_warm;
    n.irq = irq_request && (nx == pms_wdog || nx == pms_on);
    n.pclk_en = fn_powered(nx);
    unique case (nx)
      // Next control value, so a write in the last wait cycle counts
      pms_memh: n.mclk_en = n.ctrl[PMS_CTRL_OVRD];
      pms_uoff: n.mclk_en = (n.ctrl[PMS_CTRL_MCUCLK]
                             && n.ctrl[PMS_CTRL_UOCLK])
                            || n.ctrl[PMS_CTRL_OVRD];
      default: n.mclk_en = fn_powered(nx);
    endcase
    // Regulators: linear off in low power states
    n.ldo_en = fn_awake(nx) || (fn_powered(nx) && n.seq);
    n.buck_lp = '0;
    unique case (nx)
      pms_wdog, pms_on, pms_uow: n.buck_en = '1;
      pms_cold, pms_warm: n.buck_en = n.keep | {PMS_NBUCK{n.seq}};
      pms_memh: begin
        n.buck_en = q.mhm;
        n.buck_lp = q.mhm;
      end
      pms_uoff: n.buck_en = q.uom;
      default: n.buck_en = '0;
    endcase
  end

  assign enter = (nx != q.st);

  // Coin-cell power-on reset lands in coin cell
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= pms_coin;
      q.ctrl <= PMS_CTRL_RST;
      q.mhm <= PMS_MODE_RST;
      q.uom <= PMS_MODE_RST;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  // Open-drain: drive low while the reset is asserted
  assign system_reset_n_out = q.sys_rst_n;
  assign system_reset_n_oe = ~q.sys_rst_n;
  assign processor_reset_n_out = q.mcu_rst_n;
  assign processor_reset_n_oe = ~q.mcu_rst_n;
  assign irq_out = q.irq;
  // Gating with a registered enable; may clip one slow pulse
  assign peripheral_slow_clock = slow_clock_in & q.pclk_en;
  assign processor_slow_clock = slow_clock_in & q.mclk_en;
  assign buck_enable = q.buck_en;
  assign buck_low_power = q.buck_lp;
  assign ldo_enable = q.ldo_en;
  assign regulator_seq_go = q.seq;
  assign pups_latched = q.pups;
  assign reg_rdata = q.rdata;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_bus_gate;
    reg_rd && !fn_awake(q.st) |=> reg_rdata == '0;
  endproperty
  a_bus_gate: assert property (p_bus_gate)
    else $error("read answered outside awake states");

  property p_irq_gate;
    !(q.st == pms_wdog || q.st == pms_on) |-> !irq_out;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt high outside watchdog and on");

  property p_coin;
    q.st == pms_coin |-> !system_reset_n_out && !processor_reset_n_out;
  endproperty
  a_coin: assert property (p_coin)
    else $error("reset released in coin cell");

  property p_coin_wipe;
    q.st == pms_coin && !backup_cell_ok |=> q.ctrl == PMS_CTRL_RST;
  endproperty
  a_coin_wipe: assert property (p_coin_wipe)
    else $error("settings survived backup collapse");

  property p_off_uv;
    q.st == pms_off && !aon_ok |=> q.st == pms_off;
  endproperty
  a_off_uv: assert property (p_off_uv)
    else $error("off left with supply low");

  property p_on_drop;
    q.st == pms_on && aon_ok && !q.uoreq && !keepalive_input |=>
      q.st == ($past(q.ctrl[PMS_CTRL_SILENT]) ? pms_cold : pms_off);
  endproperty
  a_on_drop: assert property (p_on_drop)
    else $error("wrong exit on keepalive loss");

  property p_uow_exit;
    q.st == pms_uow && st_done && aon_ok |=>
      !q.uoreq && !system_reset_n_out && (q.st ==
      ($past(q.ctrl[PMS_CTRL_WARM_START_ENABLE]) ? pms_uoff : pms_memh));
  endproperty
  a_uow_exit: assert property (p_uow_exit)
    else $error("wait expiry handled wrongly");

  property p_memh_wake;
    q.st == pms_memh && turn_on_event |=>
      q.st == pms_cold && q.flags[PMS_FLAG_MEMH] && !regulator_seq_go;
  endproperty
  a_memh_wake: assert property (p_memh_wake)
    else $error("memory hold wake wrong");

  property p_cold_hold;
    q.st == pms_cold && aon_ok && !st_done |=>
      q.st == pms_cold && !processor_reset_n_out;
  endproperty
  a_cold_hold: assert property (p_cold_hold)
    else $error("cold start left early");

  property p_uoff_clk;
    q.st == pms_uoff |-> !peripheral_slow_clock && processor_reset_n_out
      && q.mclk_en == ((q.ctrl[PMS_CTRL_MCUCLK] && q.ctrl[PMS_CTRL_UOCLK])
      || q.ctrl[PMS_CTRL_OVRD]);
  endproperty
  a_uoff_clk: assert property (p_uoff_clk)
    else $error("user off clock or reset wrong");

  c_memh_wake: cover property (q.st == pms_memh ##1 q.st == pms_cold);
  c_warm_done: cover property (q.st == pms_warm ##1 q.st == pms_wdog);
  c_silent: cover property (q.st == pms_on ##1 q.st == pms_cold);
  c_power_cut: cover property (q.st == pms_power_cut ##1 q.st == pms_cold);

endmodule

// [tb/pms_cpu_model.sv]
`timescale 1ns/100ps
module pms_cpu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cpu_reset_n,
  input wire logic drop_req,
  output logic keepalive_input
);
  // --------------------------------------------------------------
  // Keepalive driver
  // --------------------------------------------------------------
  // Raised once the processor leaves reset, dropped on command or when its reset returns;
  // drop_req stands in for a crash and for the processor going quiet after user off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      keepalive_input <= 1'b0;
    end else begin
      keepalive_input <= cpu_reset_n && !drop_req;
    end
  end
endmodule

// [tb/pms_fsm_bench.sv]
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  $display("Error %s exp %h got %h", nm, e, g); bad_count++; end end
module pms_fsm_bench
  import pms_pkg::*;
();
  logic clk, rst_n, osc_tick, slow_clock_in, supply_ok, backup_ok;
  logic turn_on_event, keepalive_input, irq_request, drop_req;
  logic [PMS_NPUPS-1:0] pins, pups_latched;
  logic [PMS_AW-1:0] reg_addr;
  logic [PMS_DW-1:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, sys_n, sys_oe, cpu_n, cpu_oe, irq_out;
  logic per_clk, cpu_clk, ldo_enable, seq_go;
  logic [PMS_NBUCK-1:0] buck_enable, buck_low_power;
  // Free-running dividers, started from zero by their declarations
  logic [1:0] tick_cnt = 2'h0;
  logic [2:0] slow_cnt = 3'h0;
  logic [1:0] seen;
  int bad_count, n_compared;
  // Open-drain resets with board pull-ups
  wire sys_w = sys_oe ? sys_n : 1'b1;
  wire cpu_w = cpu_oe ? cpu_n : 1'b1;

  // --------------------------------------------------------------
  // Device and processor model
  // --------------------------------------------------------------
  // Long reset timer so the 8 ms init ends inside cold start
  pms_fsm #(.RESET_TICKS(16'h012c), .WDOG_TICKS(16'h0004),
    .WAIT_TICKS(16'h0004), .POWER_CUT_TICKS(16'h0004)) dut (
    .clk(clk), .rst_n(rst_n), .osc_tick(osc_tick),
    .slow_clock_in(slow_clock_in), .always_on_supply_ok(supply_ok),
    .backup_cell_ok(backup_ok), .turn_on_event(turn_on_event),
    .keepalive_input(keepalive_input), .irq_request(irq_request),
    .power_up_select_pins(pins), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .system_reset_n_out(sys_n),
    .system_reset_n_oe(sys_oe), .processor_reset_n_out(cpu_n),
    .processor_reset_n_oe(cpu_oe), .irq_out(irq_out),
    .peripheral_slow_clock(per_clk), .processor_slow_clock(cpu_clk),
    .buck_enable(buck_enable), .buck_low_power(buck_low_power),
    .ldo_enable(ldo_enable), .regulator_seq_go(seq_go),
    .pups_latched(pups_latched));
  pms_cpu_model cpu (.clk(clk), .rst_n(rst_n), .cpu_reset_n(cpu_w),
    .drop_req(drop_req), .keepalive_input(keepalive_input));

  // --------------------------------------------------------------
  // Clocks
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Oscillator tick every 4 cycles keeps timer runs short
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    osc_tick <= (tick_cnt == 2'h3);
    slow_cnt <= slow_cnt + 3'h1;
    slow_clock_in <= slow_cnt[2];
  end

  // --------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------
  task automatic wr(input logic [PMS_AW-1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [PMS_AW-1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic rck(input logic [PMS_AW-1:0] a, input logic [7:0] e,
                     input string nm);
    logic [7:0] d;
    rd(a, d);
    `CHK(nm, e, d)
  endtask
  // Poll the state code; reads outside the bus states give 0
  task automatic wait_st(input logic [7:0] s);
    logic [7:0] d;
    int i;
    d = 8'h00;
    for (i = 0; i < 2500 && d !== s; i++) begin
      rd(PMS_ADDR_STATE, d);
    end
    `CHK("state", s, d)
  endtask
  task automatic wait_sys(input logic v);
    int i;
    for (i = 0; i < 5000 && sys_w !== v; i++) begin
      @(posedge clk);
    end
    #1;
    `CHK("sys_reset", v, sys_w)
  endtask
  task automatic ton;
    @(posedge clk);
    turn_on_event <= 1'b1;
    @(posedge clk);
    turn_on_event <= 1'b0;
  endtask
  task automatic watch_clk;
    seen = 2'b00;
    repeat (20) begin
      @(posedge clk);
      #1;
      seen = seen | {per_clk, cpu_clk};
    end
  endtask
  task automatic end_sim;
    $display("Compared %0d, errors %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // Watchdog against a hung sequence
  // --------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    end_sim();
  end

  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial begin
    {rst_n, turn_on_event, drop_req} = 3'h0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 13'h0000;
    {supply_ok, backup_ok, irq_request} = 3'h7;
    pins = 4'ha;
    bad_count = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    `CHK("sys_reset", 1'b0, sys_w)
    `CHK("cpu_reset", 1'b0, cpu_w)
    `CHK("irq", 1'b0, irq_out)
    wr(PMS_ADDR_CTRL, 8'h01);
    rck(PMS_ADDR_STATE, 8'h00, "st_off");
    // Turn-on with the supply low must not leave off
    @(posedge clk);
    supply_ok <= 1'b0;
    ton();
    repeat (40) @(posedge clk);
    #1;
    `CHK("pups", 4'h0, pups_latched)
    @(posedge clk);
    supply_ok <= 1'b1;
    ton();
    repeat (5) @(posedge clk);
    #1;
    `CHK("pups", 4'ha, pups_latched)
    `CHK("seq_go", 1'b0, seq_go)
    repeat (1000) @(posedge clk);
    #1;
    `CHK("seq_go", 1'b0, seq_go)
    repeat (80) @(posedge clk);
    #1;
    `CHK("seq_go", 1'b1, seq_go)
    `CHK("ldo", 1'b1, ldo_enable)
    `CHK("cpu_reset", 1'b0, cpu_w)
    wait_sys(1'b1);
    `CHK("cpu_reset", 1'b1, cpu_w)
    `CHK("irq", 1'b1, irq_out)
    rck(PMS_ADDR_STATE, 8'h03, "st_wdog");
    rck(PMS_ADDR_CTRL, 8'h00, "ctrl");
    wr(PMS_ADDR_MHMODE, 8'h08);
    wait_st(8'h04);
    // Both slow clocks run in on, so the later gating means something
    watch_clk();
    `CHK("clocks", 2'b11, seen)
    // User off with warm starts disabled ends in memory hold
    wr(PMS_ADDR_USEROFF, 8'h01);
    rck(PMS_ADDR_STATE, 8'h05, "st_uow");
    @(posedge clk);
    drop_req <= 1'b1;
    // Let the low keepalive be sampled before the state is read back
    repeat (2) @(posedge clk);
    rck(PMS_ADDR_STATE, 8'h05, "st_uow");
    wait_sys(1'b0);
    watch_clk();
    `CHK("clocks", 2'b00, seen)
    `CHK("cpu_reset", 1'b0, cpu_w)
    `CHK("bucks", 5'h08, buck_enable)
    `CHK("buck_lp", 5'h08, buck_low_power)
    `CHK("ldo", 1'b0, ldo_enable)
    `CHK("irq", 1'b0, irq_out)
    rck(PMS_ADDR_STATE, 8'h00, "st_memh");
    @(posedge clk);
    drop_req <= 1'b0;
    pins <= 4'h5;
    ton();
    repeat (5) @(posedge clk);
    #1;
    `CHK("bucks", 1'b1, buck_enable[3])
    `CHK("pups", 4'h5, pups_latched)
    wait_sys(1'b1);
    rck(PMS_ADDR_FLAGS, 8'h01, "flags");
    rck(PMS_ADDR_MHMODE, 8'h00, "mhmode");
    rck(PMS_ADDR_USEROFF, 8'h00, "useroff");
    wr(PMS_ADDR_FLAGS, 8'h01);
    wait_st(8'h04);
    // Warm path with the processor clock kept alive
    wr(PMS_ADDR_CTRL, 8'h0d);
    wr(PMS_ADDR_UOMODE, 8'h09);
    wr(PMS_ADDR_USEROFF, 8'h01);
    wait_sys(1'b0);
    watch_clk();
    `CHK("clocks", 2'b01, seen)
    `CHK("cpu_reset", 1'b1, cpu_w)
    `CHK("bucks", 5'h09, buck_enable)
    ton();
    repeat (5) @(posedge clk);
    #1;
    `CHK("sys_reset", 1'b0, sys_w)
    `CHK("cpu_reset", 1'b1, cpu_w)
    wait_sys(1'b1);
    rck(PMS_ADDR_STATE, 8'h03, "st_wdog");
    rck(PMS_ADDR_FLAGS, 8'h02, "flags");
    rck(PMS_ADDR_UOMODE, 8'h00, "uomode");
    wait_st(8'h04);
    // Silent restart returns without any turn-on
    wr(PMS_ADDR_CTRL, 8'h02);
    @(posedge clk);
    drop_req <= 1'b1;
    wait_sys(1'b0);
    @(posedge clk);
    drop_req <= 1'b0;
    wait_sys(1'b1);
    wait_st(8'h04);
    // Short supply loss with power cut support recovers to cold start
    wr(PMS_ADDR_CTRL, 8'h20);
    @(posedge clk);
    supply_ok <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    `CHK("sys_reset", 1'b0, sys_w)
    @(posedge clk);
    supply_ok <= 1'b1;
    wait_sys(1'b1);
    wait_st(8'h04);
    // Keepalive loss with silent restart off parks in off
    wr(PMS_ADDR_CTRL, 8'h00);
    @(posedge clk);
    drop_req <= 1'b1;
    wait_sys(1'b0);
    @(posedge clk);
    drop_req <= 1'b0;
    repeat (2000) @(posedge clk);
    #1;
    `CHK("sys_reset", 1'b0, sys_w)
    // Second power-on with supply and backup cell low parks in coin cell
    @(posedge clk);
    rst_n <= 1'b0;
    supply_ok <= 1'b0;
    backup_ok <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    ton();
    repeat (4) @(posedge clk);
    #1;
    `CHK("pups", 4'h0, pups_latched)
    `CHK("sys_reset", 1'b0, sys_w)
    `CHK("cpu_reset", 1'b0, cpu_w)
    // Supply back: coin cell gives way to off, then turn-on counts
    @(posedge clk);
    supply_ok <= 1'b1;
    backup_ok <= 1'b1;
    ton();
    repeat (5) @(posedge clk);
    #1;
    `CHK("pups", 4'h5, pups_latched)
    end_sim();
  end
endmodule
